// ### bench/pwx_rc_model.sv
// Behavioural low-pass load on the channel A pin
`timescale 1ns/1ps
module pwx_rc_model (
	input  wire logic clk_in,
	input  wire logic pin_in,
	input  wire logic pin_oe_n_in,
	output int        charge_out
);
	// Charge grows only while the pin is driven high, so it averages the duty
	initial charge_out = 0;
	always @(posedge clk_in) begin
		if (!pin_oe_n_in && pin_in === 1'b1) begin
			charge_out <= charge_out + 1;
		end
	end
endmodule // pwx_rc_model

// ### bench/pwx_top_properties.sv
// Port-level checker for the pulse-width converter
`timescale 1ns/1ps
module pwx_checker (
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic [23:0] addr_in,
	input wire logic [7:0]  wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [7:0]  rdata_out,
	input wire logic        pin_out,
	input wire logic        pin_oe_n_out
);
	logic acc_ff;
	logic pair_ff;
	logic stop_ff;
	logic hit;

	// Shadow copies of access gate, pair select and unit stop
	assign hit = addr_in inside {pwx_pkg::ADR_DATA_A_HI, pwx_pkg::ADR_DATA_A_LO,
		pwx_pkg::ADR_PAIR_HI, pwx_pkg::ADR_PAIR_LO};
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc_ff  <= 1'b0;
			pair_ff <= 1'b0;
			stop_ff <= 1'b1;
		end else if (wr_in) begin
			if (addr_in == pwx_pkg::ADR_SER_CTL) acc_ff <= wdata_in[4] | wdata_in[0];
			if (addr_in == pwx_pkg::ADR_PAIR_LO && acc_ff) pair_ff <= wdata_in[0];
			if (addr_in == pwx_pkg::ADR_STOP_CTL) stop_ff <= wdata_in[3];
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	idle_read_zero_a: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data not zero outside a read");
	unmapped_read_a: assert property (rd_in && addr_in[23:8] != 16'hFFFF |=> rdata_out == 8'h00)
		else $error("unmapped read returned data");
	access_gate_a: assert property (rd_in && hit && !acc_ff |=> rdata_out == 8'h00)
		else $error("gated register readable");
	low_bit_one_a: assert property (rd_in && acc_ff && !pair_ff &&
		addr_in == pwx_pkg::ADR_DATA_A_LO |=> rdata_out[0]) else $error("data low bit0 not one");
	pair_hide_a: assert property (rd_in && acc_ff && pair_ff &&
		addr_in == pwx_pkg::ADR_DATA_A_LO |=> rdata_out == 8'h00) else $error("hidden byte read");
	pair_readback_a: assert property (rd_in && acc_ff && addr_in == pwx_pkg::ADR_PAIR_LO
		|=> rdata_out[0] == $past(pair_ff)) else $error("pair select readback wrong");
	dir_readback_a: assert property (rd_in && addr_in == pwx_pkg::ADR_PORT4_DIR
		|=> rdata_out[6] == !pin_oe_n_out) else $error("pin enable disagrees with direction");
	stop_hold_a: assert property (stop_ff && $past(stop_ff) && !wr_in && !$past(wr_in)
		|=> $stable(pin_out)) else $error("pin moved while unit stopped");
endmodule // pwx_checker

bind pwx_top pwx_checker u_chk (
	.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_out(pin_out),
	.pin_oe_n_out(pin_oe_n_out)
);

// ### bench/pwx_top_test.sv
// Self-checking bench for the pulse-width converter
`timescale 1ns/1ps
module pwx_top_test;
	localparam int DIV_TOP = 8;
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [23:0] addr_in = 24'h000000;
	logic [7:0]  wdata_in = 8'h00;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [7:0]  rdata_out;
	logic        pin_out;
	logic        pin_oe_n_out;
	int          charge;
	int          err_total = 0;
	int          n_checks = 0;

	always #5 clk_in = ~clk_in;

	pwx_top #(.DIV_TOP(DIV_TOP)) DUT (
		.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_out(pin_out),
		.pin_oe_n_out(pin_oe_n_out)
	);
	pwx_rc_model u_load (.clk_in(clk_in), .pin_in(pin_out), .pin_oe_n_in(pin_oe_n_out),
		.charge_out(charge));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] e);
		n_checks++;
		if (seen !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, seen);
		end
	endtask
	task automatic finish_test;
		if (err_total == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [23:0] a, output logic [7:0] d);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		d = rdata_out;
		@(posedge clk_in);
	endtask
	task automatic rdchk(input string n, input logic [23:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		check(n, {8'h00, d}, {8'h00, e});
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		@(negedge clk_in);
		check("pin", {15'h0000, pin_out}, 16'h0000);
		check("pin_oe_n", {15'h0000, pin_oe_n_out}, 16'h0001);
		@(posedge clk_in);
		rdchk("stop_ctl", pwx_pkg::ADR_STOP_CTL, 8'h08);
		rdchk("gated_hi", pwx_pkg::ADR_DATA_A_HI, 8'h00);
	endtask
	task automatic t_regs;
		wr(pwx_pkg::ADR_SER_CTL, 8'h10);
		wr(pwx_pkg::ADR_DATA_A_HI, 8'h12);
		wr(pwx_pkg::ADR_DATA_A_LO, 8'h34);
		rdchk("data_hi", pwx_pkg::ADR_DATA_A_HI, 8'h12);
		rdchk("data_lo", pwx_pkg::ADR_DATA_A_LO, 8'h35);
		wr(pwx_pkg::ADR_SER_CTL, 8'h00);
		rdchk("gated_lo", pwx_pkg::ADR_DATA_A_LO, 8'h00);
		wr(pwx_pkg::ADR_SER_CTL, 8'h01);
		rdchk("relocated", pwx_pkg::ADR_DATA_A_LO, 8'h35);
	endtask
	task automatic t_pair;
		wr(pwx_pkg::ADR_PAIR_LO, 8'h01);
		rdchk("hidden_lo", pwx_pkg::ADR_DATA_A_LO, 8'h00);
		wr(pwx_pkg::ADR_PAIR_HI, 8'h05);
		wr(pwx_pkg::ADR_PAIR_LO, 8'hF1);
		rdchk("count_hi", pwx_pkg::ADR_PAIR_HI, 8'h05);
		rdchk("count_lo", pwx_pkg::ADR_PAIR_LO, 8'hF3);
		rdchk("unmapped", 24'hFFFF90, 8'h00);
	endtask
	task automatic steps(input int p, input logic [5:0] e);
		logic [7:0] r1;
		logic [7:0] r2;
		repeat (p) @(posedge clk_in);
		rd(pwx_pkg::ADR_PAIR_LO, r1);
		repeat (p - 2) @(posedge clk_in);
		rd(pwx_pkg::ADR_PAIR_LO, r2);
		check("count_step", {10'h000, r2[7:2] - r1[7:2]}, {10'h000, e});
	endtask
	task automatic t_prescale;
		int per [8] = '{2, 64, 128, 256, 1024, 4096, DIV_TOP, 16};
		logic [2:0] c;
		wr(pwx_pkg::ADR_DATA_A_HI, 8'h01);
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr(pwx_pkg::ADR_STOP_CTL, 8'h08);
			wr(pwx_pkg::ADR_CLK_SEL, {2'b00, c[1], c[0], 3'b000, c[2]});
			wr(pwx_pkg::ADR_STOP_CTL, 8'h00);
			steps(per[i], (i == 7) ? 6'h00 : 6'h01);
		end
		wr(pwx_pkg::ADR_DATA_A_HI, 8'h00);
		steps(2, 6'h02);
	endtask
	task automatic t_dir;
		wr(pwx_pkg::ADR_PORT4_DIR, 8'h40);
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		check("pin_oe_n", {15'h0000, pin_oe_n_out}, 16'h0000);
		@(posedge clk_in);
		rdchk("port_dir", pwx_pkg::ADR_PORT4_DIR, 8'h40);
	endtask
	task automatic wave(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ctl,
			input logic [7:0] stop, input logic [15:0] e);
		int c0;
		wr(pwx_pkg::ADR_STOP_CTL, stop);
		wr(pwx_pkg::ADR_PAIR_LO, 8'h00);
		wr(pwx_pkg::ADR_DATA_A_HI, hi);
		wr(pwx_pkg::ADR_DATA_A_LO, lo);
		wr(pwx_pkg::ADR_PAIR_LO, 8'h01);
		wr(pwx_pkg::ADR_DATA_A_HI, ctl);
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		c0 = charge;
		// One full counter period gives an exact high-cycle total
		repeat (16384) @(negedge clk_in);
		check("pin_high_cycles", 16'(charge - c0), e);
		@(posedge clk_in);
	endtask
	task automatic t_off;
		wr(pwx_pkg::ADR_DATA_A_HI, 8'h02);
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		check("pin_disabled", {15'h0000, pin_out}, 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#950000;
		err_total++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		t_reset();
		t_regs();
		t_pair();
		t_prescale();
		t_dir();
		wave(8'h40, 8'h0E, 8'h06, 8'h00, 16'h2FFD);
		wave(8'h00, 8'h82, 8'h04, 8'h00, 16'h0000);
		wave(8'h44, 8'h08, 8'h04, 8'h00, 16'h1108);
		wave(8'h40, 8'h0E, 8'h06, 8'h08, 16'h4000);
		t_off();
		finish_test();
	end
endmodule // pwx_top_test

// ### logic/pwx_prescale.sv
// Counter input clock prescaler
`timescale 1ns/1ps
module pwx_prescale #(
	parameter int DIV_TOP = 16384
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	pwx_clk_if.pre   clk_if
);

	logic [pwx_pkg::DIV_W-1:0] div_cnt_ff;
	logic [pwx_pkg::DIV_W-1:0] period;

	// Period of one resolution step; zero means no ticks
	function automatic logic [pwx_pkg::DIV_W-1:0] period_of(
		input logic       clock_source_bit,
		input logic [2:0] code
	);
		if (!clock_source_bit) begin
			return pwx_pkg::DIV_1; // [R13]
		end
		case (code) // [R07]
			3'h0:    return pwx_pkg::DIV_2;
			3'h1:    return pwx_pkg::DIV_64;
			3'h2:    return pwx_pkg::DIV_128;
			3'h3:    return pwx_pkg::DIV_256;
			3'h4:    return pwx_pkg::DIV_1024;
			3'h5:    return pwx_pkg::DIV_4096;
			3'h6:    return pwx_pkg::DIV_W'(DIV_TOP);
			default: return pwx_pkg::DIV_NONE;
		endcase
	endfunction

	assign period = period_of(clk_if.clock_source_bit, clk_if.code); // [R06]

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div_cnt_ff  <= '0;
			clk_if.tick <= 1'b0;
		end else if (!clk_if.run || period == pwx_pkg::DIV_NONE) begin
			div_cnt_ff  <= '0;
			clk_if.tick <= 1'b0;
		end else if (div_cnt_ff >= period - 15'h0001) begin
			div_cnt_ff  <= '0;
			clk_if.tick <= 1'b1;
		end else begin
			div_cnt_ff  <= div_cnt_ff + 15'h0001;
			clk_if.tick <= 1'b0;
		end
	end

endmodule // pwx_prescale

// ### logic/pwx_top.sv
// 14-bit pulse-width converter with register port and channel A pin
//
// Contract
// R01: Pair select bit 0 shows data registers, 1 shows control and counter.
// R02: Data bits 13..6 set the duty within each base cycle (code: only bits 13..8 with carrier select 0).
// R03: Data bits 5..0 decide extra pulses over the base cycles.
// R04: Carrier select 0: base cycle 64 steps, data valid 0x0100..0x3FFF.
// R05: Carrier select 1: base cycle 256 steps, data valid 0x0040..0x3FFF.
// R06: Three prescaler bits pick the step clock only when clock select is 1.
// R07: Codes 0..6 give 2,64,128,256,1024,4096,16384 cycles; code 7 forbidden.
// R08: Without relocation, registers reachable only while access enable is set.
// R09: Unit stop bit 1 halts the unit; 0 lets it run.
// R10: Software sets the pin direction bit to output for the waveform.
// R11: A readable, writable 14-bit up counter counts steps as time base.
// R12: Data outside the valid range holds the output at a constant level.
// R13: Clock select 0 gives one system cycle per step, prescaler ignored.
// R14: Phase select inverts the output; channel A enable gates it onto the pin.
// R15: Output active while low count below duty; extra pulses widen by one step.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module pwx_top #(
	parameter int DIV_TOP = 16384
) (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic [23:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [7:0]  rdata_out,
	output logic             pin_out,
	output logic             pin_oe_n_out
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [2:0]                    presc_code_ff;
	logic [7:0]                    stop_ctl_ff;
	logic [pwx_pkg::DUTY_W-1:0]    duty_a_ff;
	logic [pwx_pkg::EXTRA_W-1:0]   extra_a_ff;
	logic                          cfs_a_ff;
	logic [pwx_pkg::DUTY_W-1:0]    duty_b_ff;
	logic [pwx_pkg::EXTRA_W-1:0]   extra_b_ff;
	logic                          cfs_b_ff;
	logic                          oe_a_ff;
	logic                          os_ff;
	logic                          cks_ff;
	logic                          pair_sel_ff;
	logic [pwx_pkg::CNT_W-1:0]     cnt_ff;
	logic [7:0]                    port4_dir_ff;
	logic [7:0]                    ser_ctl_ff;
	logic [7:0]                    rdata_ff;
	logic                          pin_ff;
	logic                          pin_oe_n_ff;

	////////////////////////////////////////////////////////////////////////
	// Decode
	// Pair select decides which view a data-address write reaches

	logic                          acc_ok;
	logic                          running;
	logic                          hit_clk;
	logic                          hit_stop;
	logic                          hit_a_hi;
	logic                          hit_a_lo;
	logic                          hit_p_hi;
	logic                          hit_p_lo;
	logic                          hit_dir;
	logic                          hit_ser;
	logic                          wr_data;
	logic                          wr_ctrl;
	logic [7:0]                    nxt_rdata;

	pwx_clk_if clk_if ();

	// Byte holding the low data bits, carrier select and a fixed one
	function automatic logic [7:0] low_byte(
		input logic [pwx_pkg::EXTRA_W-1:0] extra,
		input logic                        carrier_freq_select
	);
		logic [7:0] b;
		b = {extra, 2'h0};
		b[pwx_pkg::BIT_CFS]     = carrier_freq_select;
		b[pwx_pkg::BIT_LSB_ONE] = 1'b1;
		return b;
	endfunction

	// Address match
	function automatic logic hit(
		input logic [23:0] a,
		input logic [23:0] ref_adr
	);
		return a == ref_adr;
	endfunction

	// Data A and pair registers are gated off unless relocated or access enabled
	assign acc_ok = ser_ctl_ff[pwx_pkg::BIT_RELOC]
	              | ser_ctl_ff[pwx_pkg::BIT_ACC_EN]; // [R08]
	assign running = ~stop_ctl_ff[pwx_pkg::BIT_UNIT_STOP]; // [R09]

	assign hit_clk  = hit(addr_in, pwx_pkg::ADR_CLK_SEL);
	assign hit_stop = hit(addr_in, pwx_pkg::ADR_STOP_CTL);
	assign hit_a_hi = hit(addr_in, pwx_pkg::ADR_DATA_A_HI) & acc_ok; // [R08]
	assign hit_a_lo = hit(addr_in, pwx_pkg::ADR_DATA_A_LO) & acc_ok; // [R08]
	assign hit_p_hi = hit(addr_in, pwx_pkg::ADR_PAIR_HI) & acc_ok; // [R08]
	assign hit_p_lo = hit(addr_in, pwx_pkg::ADR_PAIR_LO) & acc_ok; // [R08]
	assign hit_dir  = hit(addr_in, pwx_pkg::ADR_PORT4_DIR);
	assign hit_ser  = hit(addr_in, pwx_pkg::ADR_SER_CTL);

	assign wr_data = wr_in & ~pair_sel_ff; // [R01]
	assign wr_ctrl = wr_in & pair_sel_ff; // [R01]

	////////////////////////////////////////////////////////////////////////
	// System registers outside the converter
	// These stay writable while the unit is stopped

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			presc_code_ff <= '0;
			stop_ctl_ff   <= pwx_pkg::RST_STOP_CTL;
			port4_dir_ff  <= pwx_pkg::RST_BYTE;
			ser_ctl_ff    <= pwx_pkg::RST_BYTE;
		end else if (wr_in) begin
			if (hit_clk) begin
				presc_code_ff <= {wdata_in[pwx_pkg::BIT_PRE_C],
				                  wdata_in[pwx_pkg::BIT_PRE_B],
				                  wdata_in[pwx_pkg::BIT_PRE_A]}; // [R06]
			end
			if (hit_stop) begin
				stop_ctl_ff <= wdata_in; // [R09]
			end
			if (hit_dir) begin
				port4_dir_ff <= wdata_in;
			end
			if (hit_ser) begin
				ser_ctl_ff <= wdata_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data registers A and B
	// Channel B is stored and read back only; it drives no pin

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			duty_a_ff  <= '0;
			extra_a_ff <= '0;
			cfs_a_ff   <= 1'b0;
		end else if (wr_data && hit_a_hi) begin
			duty_a_ff <= wdata_in; // [R02]
		end else if (wr_data && hit_a_lo) begin
			extra_a_ff <= wdata_in[7:pwx_pkg::LOW_SHIFT]; // [R03]
			cfs_a_ff   <= wdata_in[pwx_pkg::BIT_CFS];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			duty_b_ff  <= '0;
			extra_b_ff <= '0;
			cfs_b_ff   <= 1'b0;
		end else if (wr_data && hit_p_hi) begin
			duty_b_ff <= wdata_in; // [R01]
		end else if (wr_data && hit_p_lo) begin
			extra_b_ff <= wdata_in[7:pwx_pkg::LOW_SHIFT];
			cfs_b_ff   <= wdata_in[pwx_pkg::BIT_CFS];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register and pair select
	// Control bits are reached only through the control view

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			oe_a_ff <= 1'b0;
			os_ff   <= 1'b0;
			cks_ff  <= 1'b0;
		end else if (wr_ctrl && hit_a_hi) begin
			oe_a_ff <= wdata_in[pwx_pkg::BIT_OEA]; // [R14]
			os_ff   <= wdata_in[pwx_pkg::BIT_OS]; // [R14]
			cks_ff  <= wdata_in[pwx_pkg::BIT_CKS]; // [R13]
		end
	end

	// Pair select sits in the low pair byte and is writable in both views
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pair_sel_ff <= 1'b0;
		end else if (wr_in && hit_p_lo) begin
			pair_sel_ff <= wdata_in[pwx_pkg::BIT_PAIR_SEL]; // [R01]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time base counter
	// With clock select 1, prescaler code 7 gives no ticks, so the count stalls
	// Stop holds the prescaler at zero and freezes the count

	assign clk_if.run  = running; // [R09]
	assign clk_if.clock_source_bit  = cks_ff; // [R06]
	assign clk_if.code = presc_code_ff;

	pwx_prescale #(
		.DIV_TOP (DIV_TOP)
	) u_prescale (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.clk_if  (clk_if)
	);

	// Software load wins over a count in the same cycle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_ff <= '0;
		end else if (wr_ctrl && hit_p_hi) begin
			cnt_ff[pwx_pkg::CNT_W-1:pwx_pkg::EXTRA_W] <= wdata_in; // [R11]
		end else if (wr_ctrl && hit_p_lo) begin
			cnt_ff[pwx_pkg::EXTRA_W-1:0] <= wdata_in[7:pwx_pkg::LOW_SHIFT]; // [R11]
		end else if (running && clk_if.tick) begin
			cnt_ff <= cnt_ff + 14'h0001; // [R11]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Waveform for channel A
	// Only the lower bound of the valid range needs a test;
	// the upper bound is the full 14-bit value

	logic [7:0]                  low_cnt;
	logic [7:0]                  duty_cmp;
	logic [pwx_pkg::EXTRA_W-1:0] base_idx;
	logic                        add_pulse;
	logic                        data_ok;
	logic                        wave;

	// Bit reversal spreads the extra pulses evenly over the period
	function automatic logic [pwx_pkg::EXTRA_W-1:0] rev6(
		input logic [pwx_pkg::EXTRA_W-1:0] v
	);
		logic [pwx_pkg::EXTRA_W-1:0] r;
		r = '0;
		for (int i = 0; i < pwx_pkg::EXTRA_W; i++) begin
			r[i] = v[pwx_pkg::EXTRA_W-1-i];
		end
		return r;
	endfunction

	always_comb begin
		if (cfs_a_ff) begin
			low_cnt  = cnt_ff[7:0]; // [R05]
			duty_cmp = duty_a_ff; // [R02]
			base_idx = cnt_ff[13:8];
		end else begin
			low_cnt  = {2'h0, cnt_ff[5:0]}; // [R04]
			duty_cmp = {2'h0, duty_a_ff[7:2]}; // [R02]
			base_idx = cnt_ff[11:6];
		end
	end

	// Lower bound of the valid range is a nonzero compare value
	assign data_ok   = duty_cmp != 8'h00; // [R04] [R05] [R12]
	assign add_pulse = rev6(base_idx) < extra_a_ff; // [R03] [R15]
	assign wave      = data_ok && running
	                 && ((low_cnt < duty_cmp)
	                 || (add_pulse && low_cnt == duty_cmp)); // [R15] [R12]

	////////////////////////////////////////////////////////////////////////
	// Pin drive
	// Disabled channel stays low whatever the phase
	// Direction bit set means drive; the enable is active low

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_ff      <= 1'b0;
			pin_oe_n_ff <= 1'b1;
		end else begin
			pin_ff      <= oe_a_ff & (wave ^ os_ff); // [R14]
			pin_oe_n_ff <= ~port4_dir_ff[pwx_pkg::BIT_PIN_DIR]; // [R10]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	// Gated, hidden and unmapped addresses read as zero

	always_comb begin
		nxt_rdata = 8'h00;
		if (hit_clk) begin
			nxt_rdata[pwx_pkg::BIT_PRE_C] = presc_code_ff[2];
			nxt_rdata[pwx_pkg::BIT_PRE_B] = presc_code_ff[1];
			nxt_rdata[pwx_pkg::BIT_PRE_A] = presc_code_ff[0];
		end else if (hit_stop) begin
			nxt_rdata = stop_ctl_ff;
		end else if (hit_dir) begin
			nxt_rdata = port4_dir_ff;
		end else if (hit_ser) begin
			nxt_rdata = ser_ctl_ff;
		end else if (hit_a_hi) begin
			if (pair_sel_ff) begin
				nxt_rdata[pwx_pkg::BIT_OEA] = oe_a_ff; // [R01]
				nxt_rdata[pwx_pkg::BIT_OS]  = os_ff;
				nxt_rdata[pwx_pkg::BIT_CKS] = cks_ff;
			end else begin
				nxt_rdata = duty_a_ff;
			end
		end else if (hit_a_lo) begin
			if (!pair_sel_ff) begin
				nxt_rdata = low_byte(extra_a_ff, cfs_a_ff);
			end
		end else if (hit_p_hi) begin
			if (pair_sel_ff) begin
				nxt_rdata = cnt_ff[pwx_pkg::CNT_W-1:pwx_pkg::EXTRA_W]; // [R11]
			end else begin
				nxt_rdata = duty_b_ff;
			end
		end else if (hit_p_lo) begin
			if (pair_sel_ff) begin
				nxt_rdata = {cnt_ff[pwx_pkg::EXTRA_W-1:0], 2'h0}; // [R11]
				nxt_rdata[pwx_pkg::BIT_CFS] = 1'b1;
			end else begin
				nxt_rdata = low_byte(extra_b_ff, cfs_b_ff);
			end
			nxt_rdata[pwx_pkg::BIT_PAIR_SEL] = pair_sel_ff; // [R01]
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_ff <= 8'h00;
		end else if (rd_in) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign rdata_out    = rdata_ff;
	assign pin_out      = pin_ff;
	assign pin_oe_n_out = pin_oe_n_ff;

endmodule // pwx_top

// ### shared/pwx_clk_if.sv
// Link between the converter core and its input clock prescaler
`timescale 1ns/1ps
interface pwx_clk_if;
	logic       run;
	logic       clock_source_bit;
	logic [2:0] code;
	logic       tick;

	modport ctl (output run, output clock_source_bit, output code, input tick);
	modport pre (input run, input clock_source_bit, input code, output tick);
endinterface

// ### shared/pwx_pkg.sv
// Constants for the 14-bit pulse-width converter unit
package pwx_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus widths
	localparam int ADDR_W  = 24;
	localparam int DATA_W  = 8;
	localparam int CNT_W   = 14;
	localparam int DUTY_W  = 8;
	localparam int EXTRA_W = 6;
	localparam int DIV_W   = 15;

	////////////////////////////////////////////////////////////////////////
	// Register addresses
	localparam logic [23:0] ADR_CLK_SEL   = 24'hFFFF82;
	localparam logic [23:0] ADR_STOP_CTL  = 24'hFFFF86;
	localparam logic [23:0] ADR_DATA_A_HI = 24'hFFFFA0;
	localparam logic [23:0] ADR_DATA_A_LO = 24'hFFFFA1;
	localparam logic [23:0] ADR_PAIR_HI   = 24'hFFFFA6;
	localparam logic [23:0] ADR_PAIR_LO   = 24'hFFFFA7;
	localparam logic [23:0] ADR_PORT4_DIR = 24'hFFFFB5;
	localparam logic [23:0] ADR_SER_CTL   = 24'hFFFFC3;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_PRE_B     = 5;
	localparam int BIT_PRE_A     = 4;
	localparam int BIT_PRE_C     = 0;
	localparam int BIT_UNIT_STOP = 3;
	localparam int BIT_OEA       = 2;
	localparam int BIT_OS        = 1;
	localparam int BIT_CKS       = 0;
	localparam int BIT_CFS       = 1;
	localparam int BIT_LSB_ONE   = 0;
	localparam int BIT_PAIR_SEL  = 0;
	localparam int BIT_PIN_DIR   = 6;
	localparam int BIT_ACC_EN    = 4;
	localparam int BIT_RELOC     = 0;
	localparam int LOW_SHIFT     = 2;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_STOP_CTL = 8'h08;
	localparam logic [7:0] RST_BYTE     = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Prescaler periods in system clock cycles
	localparam logic [14:0] DIV_1    = 15'h0001;
	localparam logic [14:0] DIV_2    = 15'h0002;
	localparam logic [14:0] DIV_64   = 15'h0040;
	localparam logic [14:0] DIV_128  = 15'h0080;
	localparam logic [14:0] DIV_256  = 15'h0100;
	localparam logic [14:0] DIV_1024 = 15'h0400;
	localparam logic [14:0] DIV_4096 = 15'h1000;
	localparam logic [14:0] DIV_NONE = 15'h0000;

endpackage
